//--- core/etsch_pkg.sv
// Shared constants and carrier types of the egress class scheduler
package etsch_pkg;

  // ****************************************************************
  // Sizes, reset values and byte charges
  // ****************************************************************
  localparam int NUM_CLASS = 12;
  localparam int NUM_GRP   = 12;
  localparam int IDX_W     = 4;
  localparam int SET_W     = 3;
  localparam int LEN_W     = 16;
  localparam int PT_W      = 16;
  localparam int Q_W       = 20;
  localparam int DC_W      = 24;
  localparam int TOK_W     = 32;
  localparam int GAP_BYTES = 20;
  localparam int TOK_FRAC  = 4;
  localparam int CAP_SHIFT = 10;
  localparam logic [DC_W-1:0]  DC_RESET  = 24'h000000;
  localparam logic [TOK_W-1:0] TOK_RESET = 32'h00000000;
  localparam logic [PT_W-1:0]  PT_RESET  = 16'h0000;

  // ****************************************************************
  // Carrier types
  // ****************************************************************
  typedef logic [IDX_W-1:0]     etsch_idx_t;
  typedef logic [NUM_CLASS-1:0] etsch_cls_vec_t;

  typedef struct packed {
    logic [IDX_W-1:0] group;
    logic             inner;
  } etsch_class_cfg_s;

  typedef struct packed {
    logic             strict;
    logic [SET_W-1:0] prio_set;
    logic [Q_W-1:0]   quantum;
    logic [IDX_W-1:0] shaper;
  } etsch_group_cfg_s;

  typedef struct packed {
    logic        limit_en;
    logic [15:0] rate;
    logic [15:0] capacity;
  } etsch_shape_cfg_s;

  typedef struct packed {
    logic                           valid;
    logic                           class_based;
    logic [NUM_CLASS-1:0]           mask;
    logic [PT_W-1:0]                std_time;
    logic [NUM_CLASS-1:0][PT_W-1:0] cls_time;
  } etsch_pause_s;

  typedef struct packed {
    logic             valid;
    logic [IDX_W-1:0] traffic_class;
    logic [LEN_W-1:0] len;
  } etsch_txdone_s;

  typedef etsch_class_cfg_s [NUM_CLASS-1:0] etsch_class_tab_t;
  typedef etsch_group_cfg_s [NUM_GRP-1:0]   etsch_group_tab_t;
  typedef etsch_shape_cfg_s [NUM_GRP-1:0]   etsch_shape_tab_t;

endpackage

//--- core/etsch_pause_timer.sv
// Per-class pause countdown
`timescale 1ns/10ps
module etsch_pause_timer (
  input  wire logic                       clk,
  input  wire logic                       rst_n,
  input  wire logic                       load,
  input  wire logic [etsch_pkg::PT_W-1:0] load_time,
  input  wire logic                       tick,
  output logic                            paused
);

  // ****************************************************************
  // Countdown
  // ****************************************************************
  logic [etsch_pkg::PT_W-1:0] cnt_q;
  logic [etsch_pkg::PT_W-1:0] cnt_d;
  logic                       paused_d;

  // A new pause frame overrides the running count, zero releases
  always_comb begin
    cnt_d = cnt_q;
    if (load) begin
      cnt_d = load_time; // RL7 RL8
    end else if (tick && cnt_q != '0) begin
      cnt_d = cnt_q - 1'b1;
    end
    paused_d = (cnt_d != '0);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q  <= etsch_pkg::PT_RESET;
      paused <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      paused <= paused_d;
    end
  end

  a_pause_load: assert property (@(posedge clk) disable iff (!rst_n) // RL8
    load |=> paused == ($past(load_time) != '0))
    else $error("pause load not reflected");

endmodule

//--- core/etsch_token_bucket.sv
// Token bucket of one shaping group
`timescale 1ns/10ps
module etsch_token_bucket (
  input  wire logic                        clk,
  input  wire logic                        rst_n,
  input  wire etsch_pkg::etsch_shape_cfg_s cfg,
  input  wire logic                        tick,
  input  wire logic                        debit,
  input  wire logic [etsch_pkg::LEN_W-1:0] len,
  output logic                             ok
);

  // ****************************************************************
  // Credit in 1/16 byte units
  // ****************************************************************
  localparam int TW = etsch_pkg::TOK_W;

  logic signed [TW-1:0] tok_q;
  logic signed [TW-1:0] tok_d;
  logic signed [TW-1:0] cap_t;
  logic signed [TW-1:0] dbt_t;
  logic signed [TW-1:0] add_t;
  logic                 ok_d;

  // Over limit only delays frames; nothing here can drop one
  always_comb begin
    cap_t = TW'(cfg.capacity) << etsch_pkg::CAP_SHIFT;
    dbt_t = (TW'(len) + TW'(etsch_pkg::GAP_BYTES))
            << etsch_pkg::TOK_FRAC; // RL22
    add_t = tok_q + TW'(cfg.rate);
    tok_d = tok_q;
    if (tick) begin
      tok_d = (add_t > cap_t) ? cap_t : add_t;
    end
    if (debit) begin
      tok_d = tok_d - dbt_t; // RL5
    end
    ok_d = !cfg.limit_en || (tok_d > 0); // RL9 RL23
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tok_q <= etsch_pkg::TOK_RESET;
      ok    <= 1'b0;
    end else begin
      tok_q <= tok_d;
      ok    <= ok_d;
    end
  end

  a_bucket_empty: assert property (@(posedge clk) disable iff (!rst_n) // RL23
    $past(cfg.limit_en) && (tok_q <= 0) |-> !ok)
    else $error("empty bucket still eligible");

endmodule

//--- core/etsch_scheduler.sv
// Egress traffic class scheduler: eligibility, group and class choice
// ****************************************************************
// Overview of operation
// [RL1] Twelve traffic classes per port, each queued and configured alone.
// [RL2] Eligible strict-high groups go before every lower group.
// [RL3] Strict-low groups go only when no other group is eligible.
// [RL4] Classes map to groups and groups to shapers freely, runs allowed.
// [RL5] Shaping only holds frames back, never drops them.
// [RL6] Group eligible: an unpaused nonempty class and shaper under limit.
// [RL7] Standard pause pauses all classes; zero time releases all.
// [RL8] Class pause loads only the selected classes, each own time.
// [RL9] Shaper out of credit makes its scheduling groups ineligible.
// [RL10] Nonpositive deficit groups pruned while any candidate is positive.
// [RL11] All nonpositive: add quantum to each deficit, pointer to none.
// [RL12] Precedence: high, pointer, higher set, below, above, any.
// [RL13] Ties within a level go to the largest group number.
// [RL14] Pointer takes chosen round-robin group, else becomes none.
// [RL15] Class is the best unpaused nonempty class of the chosen group.
// [RL16] Preference is configured bit above the class number.
// [RL17] Strict groups have endless deficit, never pruned.
// [RL18] Strict above all round-robin groups is high, otherwise low.
// [RL19] Served group keeps service until deficit, eligibility or high.
// [RL20] One pointer only; changing set loses the old position.
// [RL21] Deficit charge lands late, when the frame length arrives.
// [RL22] Each finished frame costs twenty extra bytes of gap.
// [RL23] Token count at or below zero blocks the shaper's groups.
// [RL24] Serving group deficit drops by the reported frame length.
// [RL25] One selection per slot request, strobed with its class.
// ****************************************************************
`timescale 1ns/10ps
module etsch_scheduler (
  input  wire logic                        SYS_CLK,
  input  wire logic                        RESETN,
  input  wire etsch_pkg::etsch_class_tab_t CLASS_CFG,
  input  wire etsch_pkg::etsch_group_tab_t GROUP_CFG,
  input  wire etsch_pkg::etsch_shape_tab_t SHAPE_CFG,
  input  wire etsch_pkg::etsch_cls_vec_t   CLASS_READY,
  input  wire etsch_pkg::etsch_pause_s     PAUSE_IN,
  input  wire logic                        PAUSE_TICK,
  input  wire logic                        SHAPE_TICK,
  input  wire etsch_pkg::etsch_txdone_s    TX_DONE,
  input  wire logic                        SLOT_REQ,
  output logic                             SEL_VALID,
  output etsch_pkg::etsch_idx_t            SEL_CLASS,
  output etsch_pkg::etsch_idx_t            SEL_GROUP,
  output etsch_pkg::etsch_cls_vec_t        CLASS_PAUSED,
  output logic                             LAST_SERVED_VALID,
  output etsch_pkg::etsch_idx_t            LAST_SERVED_GROUP_POINTER
);

  localparam int NC = etsch_pkg::NUM_CLASS;
  localparam int NG = etsch_pkg::NUM_GRP;
  localparam int IW = etsch_pkg::IDX_W;
  localparam int DW = etsch_pkg::DC_W;

  logic [NC-1:0]                      pause_load;
  logic [NC-1:0][etsch_pkg::PT_W-1:0] pause_time;
  logic [NG-1:0]                      shp_ok;
  logic [NG-1:0]                      shp_debit;
  logic [NC-1:0]                      class_ok;
  logic [NC-1:0]                      class_ok_q;
  logic [NG-1:0]                      grp_elig;
  logic [NG-1:0]                      drr_elig;
  logic [NG-1:0]                      hi_elig;
  logic [NG-1:0]                      lo_elig;
  logic [NG-1:0]                      is_hi;
  logic [NG-1:0]                      pos;
  logic [NG-1:0]                      cand;
  logic [NG-1:0]                      m_b;
  logic [NG-1:0]                      m_c;
  logic [NG-1:0]                      m_d;
  logic [NG-1:0]                      m_e;
  logic                               any_pos;
  logic                               refill;
  logic                               ptr_eff;
  logic                               sel_found;
  logic                               sel_drr;
  logic [IW:0]                        pick;
  logic [IW-1:0]                      sel_grp;
  logic [IW-1:0]                      done_grp;
  logic [IW-1:0]                      best_cls;
  logic                               best_found;
  logic [IW:0]                        best_level;
  logic [IW:0]                        class_preference_level;
  logic [etsch_pkg::SET_W-1:0]        ptr_set;
  logic                               sel_valid_q;
  logic                               sel_valid_d;
  logic [IW-1:0]                      sel_class_q;
  logic [IW-1:0]                      sel_class_d;
  logic [IW-1:0]                      sel_group_q;
  logic [IW-1:0]                      sel_group_d;
  logic                               lsgp_valid_q;
  logic                               lsgp_valid_d;
  logic [IW-1:0]                      last_served_group_pointer_q;
  logic [IW-1:0]                      last_served_group_pointer_d;
  logic signed [DW-1:0]               deficit_count_q [NG];
  logic signed [DW-1:0]               deficit_count_d [NG];
  logic                               sel_hi_q;
  logic                               sel_lo_q;
  logic                               pos_seen_q;
  logic                               chosen_pos_q;

  // Highest set bit, so ties always favour the larger group
  function automatic logic [IW:0] hi_bit(input logic [NG-1:0] m);
    logic [IW:0] r;
    r = '0;
    for (int i = 0; i < NG; i++) begin
      if (m[i]) begin
        r = {1'b1, IW'(i)}; // RL13
      end
    end
    return r;
  endfunction

  // ****************************************************************
  // Pause timers and shapers
  // ****************************************************************
  always_comb begin
    for (int c = 0; c < NC; c++) begin
      pause_load[c] = PAUSE_IN.valid &&
                      (!PAUSE_IN.class_based || PAUSE_IN.mask[c]); // RL7 RL8
      pause_time[c] = PAUSE_IN.class_based ? PAUSE_IN.cls_time[c]
                                           : PAUSE_IN.std_time;
    end
  end

  for (genvar c = 0; c < NC; c++) begin : g_pause
    etsch_pause_timer u_timer (
      .clk       (SYS_CLK),
      .rst_n     (RESETN),
      .load      (pause_load[c]),
      .load_time (pause_time[c]),
      .tick      (PAUSE_TICK),
      .paused    (CLASS_PAUSED[c])
    );
  end

  assign done_grp = CLASS_CFG[TX_DONE.traffic_class].group;

  for (genvar s = 0; s < NG; s++) begin : g_shape
    assign shp_debit[s] = TX_DONE.valid &&
                          (GROUP_CFG[done_grp].shaper == IW'(s)); // RL22
    etsch_token_bucket u_bucket (
      .clk   (SYS_CLK),
      .rst_n (RESETN),
      .cfg   (SHAPE_CFG[s]),
      .tick  (SHAPE_TICK),
      .debit (shp_debit[s]),
      .len   (TX_DONE.len),
      .ok    (shp_ok[s])
    );
  end

  // ****************************************************************
  // Group eligibility
  // ****************************************************************
  always_comb begin
    int top_drr;
    top_drr  = -1;
    class_ok = CLASS_READY & ~CLASS_PAUSED;
    grp_elig = '0;
    for (int g = 0; g < NG; g++) begin
      if (!GROUP_CFG[g].strict) begin
        top_drr = g;
      end
    end
    for (int c = 0; c < NC; c++) begin
      if (class_ok[c] && CLASS_CFG[c].group < IW'(NG)) begin
        grp_elig[CLASS_CFG[c].group] = 1'b1; // RL1 RL4 RL6
      end
    end
    for (int g = 0; g < NG; g++) begin
      is_hi[g]    = GROUP_CFG[g].strict && (g > top_drr); // RL18
      grp_elig[g] = grp_elig[g] && (GROUP_CFG[g].shaper < IW'(NG)) &&
                    shp_ok[GROUP_CFG[g].shaper]; // RL6 RL9
      drr_elig[g] = grp_elig[g] && !GROUP_CFG[g].strict;
      hi_elig[g]  = grp_elig[g] && is_hi[g];
      lo_elig[g]  = grp_elig[g] && GROUP_CFG[g].strict && !is_hi[g];
      pos[g]      = deficit_count_q[g] > 0;
    end
  end

  // ****************************************************************
  // Group and class choice
  // ****************************************************************
  // Strict groups never enter cand, so deficit cannot prune them
  always_comb begin
    any_pos = |(drr_elig & pos);
    refill  = SLOT_REQ && !any_pos && (drr_elig != '0); // RL11
    cand    = any_pos ? (drr_elig & pos) : drr_elig; // RL10 RL17
    ptr_eff = lsgp_valid_q && !refill; // RL11
    ptr_set = GROUP_CFG[last_served_group_pointer_q].prio_set;
    for (int g = 0; g < NG; g++) begin
      m_b[g] = ptr_eff && cand[g] &&
               (IW'(g) == last_served_group_pointer_q); // RL12 RL19
      m_c[g] = cand[g] &&
               (!ptr_eff || GROUP_CFG[g].prio_set > ptr_set); // RL12
      m_d[g] = cand[g] && ptr_eff && (GROUP_CFG[g].prio_set == ptr_set) &&
               (IW'(g) < last_served_group_pointer_q); // RL12
      m_e[g] = cand[g] && ptr_eff && (GROUP_CFG[g].prio_set == ptr_set) &&
               (IW'(g) > last_served_group_pointer_q); // RL12
    end
    if (hi_elig != '0) begin
      pick = hi_bit(hi_elig); // RL2
    end else if (m_b != '0) begin
      pick = hi_bit(m_b);
    end else if (m_c != '0) begin
      pick = hi_bit(m_c);
    end else if (m_d != '0) begin
      pick = hi_bit(m_d);
    end else if (m_e != '0) begin
      pick = hi_bit(m_e);
    end else if (cand != '0) begin
      pick = hi_bit(cand);
    end else begin
      pick = hi_bit(lo_elig); // RL3
    end
    sel_found = pick[IW];
    sel_grp   = pick[IW-1:0];
    sel_drr   = sel_found && !GROUP_CFG[sel_grp].strict;
    best_found = 1'b0;
    best_level = '0;
    best_cls   = '0;
    class_preference_level = '0;
    for (int c = 0; c < NC; c++) begin
      class_preference_level = {CLASS_CFG[c].inner, IW'(c)}; // RL16
      if (class_ok[c] && (CLASS_CFG[c].group == sel_grp) &&
          (!best_found || class_preference_level > best_level)) begin
        best_found = 1'b1; // RL15
        best_level = class_preference_level;
        best_cls   = IW'(c);
      end
    end
  end

  // ****************************************************************
  // Selection, pointer and deficit state
  // ****************************************************************
  always_comb begin
    sel_valid_d = SLOT_REQ && sel_found && best_found; // RL25
    sel_class_d = sel_valid_d ? best_cls : sel_class_q;
    sel_group_d = sel_valid_d ? sel_grp : sel_group_q;
    lsgp_valid_d = lsgp_valid_q;
    last_served_group_pointer_d = last_served_group_pointer_q;
    if (refill) begin
      lsgp_valid_d = 1'b0; // RL11
    end
    if (sel_valid_d) begin
      lsgp_valid_d = sel_drr; // RL14 RL20
      last_served_group_pointer_d = sel_drr ? sel_grp : '0;
    end
    // Length arrives after later slots were already decided
    for (int g = 0; g < NG; g++) begin
      deficit_count_d[g] = deficit_count_q[g];
      if (refill && !GROUP_CFG[g].strict) begin
        deficit_count_d[g] = deficit_count_q[g] +
                             DW'(GROUP_CFG[g].quantum); // RL11
      end
      if (TX_DONE.valid && (done_grp == IW'(g)) &&
          !GROUP_CFG[g].strict) begin
        deficit_count_d[g] = deficit_count_d[g] - DW'(TX_DONE.len) -
                             DW'(etsch_pkg::GAP_BYTES); // RL21 RL22 RL24
      end
    end
  end

  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      sel_valid_q  <= 1'b0;
      sel_class_q  <= '0;
      sel_group_q  <= '0;
      lsgp_valid_q <= 1'b0;
      last_served_group_pointer_q <= '0;
      for (int g = 0; g < NG; g++) begin
        deficit_count_q[g] <= etsch_pkg::DC_RESET;
      end
      class_ok_q   <= '0;
      sel_hi_q     <= 1'b0;
      sel_lo_q     <= 1'b0;
      pos_seen_q   <= 1'b0;
      chosen_pos_q <= 1'b0;
    end else begin
      sel_valid_q  <= sel_valid_d;
      sel_class_q  <= sel_class_d;
      sel_group_q  <= sel_group_d;
      lsgp_valid_q <= lsgp_valid_d;
      last_served_group_pointer_q <= last_served_group_pointer_d;
      for (int g = 0; g < NG; g++) begin
        deficit_count_q[g] <= deficit_count_d[g];
      end
      class_ok_q   <= class_ok;
      sel_hi_q     <= is_hi[sel_grp];
      sel_lo_q     <= GROUP_CFG[sel_grp].strict && !is_hi[sel_grp];
      pos_seen_q   <= any_pos;
      chosen_pos_q <= pos[sel_grp];
    end
  end

  assign SEL_VALID                 = sel_valid_q;
  assign SEL_CLASS                 = sel_class_q;
  assign SEL_GROUP                 = sel_group_q;
  assign LAST_SERVED_VALID         = lsgp_valid_q;
  assign LAST_SERVED_GROUP_POINTER = last_served_group_pointer_q;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RESETN);

  sequence s_high_wait;
    SLOT_REQ && (hi_elig != '0);
  endsequence

  a_slot_strobe: assert property (SEL_VALID |-> $past(SLOT_REQ)) // RL25
    else $error("selection without slot");

  a_strict_high: assert property (s_high_wait |=> SEL_VALID && sel_hi_q) // RL2
    else $error("strict-high group not served first");

  a_strict_low: assert property (SEL_VALID && sel_lo_q |-> // RL3
    $past(drr_elig == '0 && hi_elig == '0))
    else $error("strict-low served over waiting group");

  a_ptr_load: assert property (SEL_VALID |-> // RL14
    (LAST_SERVED_VALID == !(sel_hi_q || sel_lo_q)) &&
    (!LAST_SERVED_VALID || LAST_SERVED_GROUP_POINTER == SEL_GROUP))
    else $error("pointer not loaded from choice");

  a_prune_nonpos: assert property (SEL_VALID && !sel_hi_q && // RL10
    !sel_lo_q && pos_seen_q |-> chosen_pos_q)
    else $error("nonpositive group chosen over positive");

  a_class_ready: assert property (SEL_VALID |-> class_ok_q[SEL_CLASS]) // RL15
    else $error("chosen class paused or empty");

  a_std_pause: assert property (PAUSE_IN.valid && // RL7
    !PAUSE_IN.class_based && PAUSE_IN.std_time != '0 |=> &CLASS_PAUSED)
    else $error("standard pause missed a class");

  a_pause_zero: assert property (PAUSE_IN.valid && // RL7
    !PAUSE_IN.class_based && PAUSE_IN.std_time == '0 |=> CLASS_PAUSED == '0)
    else $error("zero pause did not release");

  a_cls_pause_keep: assert property (PAUSE_IN.valid && // RL8
    PAUSE_IN.class_based && !PAUSE_TICK |=>
    ((CLASS_PAUSED ^ $past(CLASS_PAUSED)) & ~$past(PAUSE_IN.mask)) == '0)
    else $error("class pause touched unselected class");

  a_refill_add: assert property (refill && !TX_DONE.valid && // RL11
    !GROUP_CFG[0].strict |=> deficit_count_q[0] ==
    $past(deficit_count_q[0]) + DW'($past(GROUP_CFG[0].quantum)))
    else $error("quantum not added at new round");

endmodule

//--- verification/etsch_queue_model.sv
// Per-class transmit queue model facing the scheduler
`timescale 1ns/10ps
module etsch_queue_model #(
  parameter logic [15:0] FRAME_LEN = 16'h0050
) (
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  input  wire logic                  load,
  input  wire logic [11:0][3:0]      load_cnt,
  input  wire logic                  sel_valid,
  input  wire etsch_pkg::etsch_idx_t sel_class,
  output etsch_pkg::etsch_cls_vec_t  ready,
  output etsch_pkg::etsch_txdone_s   done
);
  logic [11:0][3:0] cnt_q;

  always_comb begin
    for (int c = 0; c < 12; c++) begin
      ready[c] = (cnt_q[c] != 4'h0);
    end
  end

  // ********
  // Pop on pick, report length a cycle later as a cut-through path does
  // ********
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
      done  <= '0;
    end else begin
      done.valid <= 1'b0;
      // Stale length is scrambled so a late sample cannot pass
      done.len   <= ~done.len;
      if (load) begin
        cnt_q <= load_cnt;
      end else if (sel_valid && cnt_q[sel_class] != 4'h0) begin
        cnt_q[sel_class] <= cnt_q[sel_class] - 4'h1;
        done <= {1'b1, sel_class, FRAME_LEN};
      end
    end
  end
endmodule

//--- verification/etsch_scheduler_tb.sv
// Directed bench of the egress class scheduler with queue model
`timescale 1ns/10ps
module etsch_scheduler_tb;
  logic                        SYS_CLK = 1'b0;
  logic                        RESETN = 1'b0;
  etsch_pkg::etsch_class_tab_t cls_cfg;
  etsch_pkg::etsch_group_tab_t grp_cfg;
  etsch_pkg::etsch_shape_tab_t shp_cfg;
  etsch_pkg::etsch_cls_vec_t   ready;
  etsch_pkg::etsch_cls_vec_t   paused;
  etsch_pkg::etsch_pause_s     pause = '0;
  etsch_pkg::etsch_txdone_s    done;
  etsch_pkg::etsch_idx_t       sel_cls;
  etsch_pkg::etsch_idx_t       sel_grp;
  etsch_pkg::etsch_idx_t       ls_ptr;
  logic                        sel_v;
  logic                        ls_v;
  logic                        ptick = 1'b0;
  logic                        stick = 1'b0;
  logic                        slot = 1'b0;
  logic                        load = 1'b0;
  logic [11:0][3:0]            cnt = '0;
  logic [3:0]                  drr_seq [5] = '{1, 1, 0, 0, 1};
  int                          err_count = 0;
  int                          n_checks = 0;

  always #20 SYS_CLK = ~SYS_CLK;

  etsch_scheduler u_etsch_scheduler (
    .SYS_CLK(SYS_CLK), .RESETN(RESETN), .CLASS_CFG(cls_cfg),
    .GROUP_CFG(grp_cfg), .SHAPE_CFG(shp_cfg), .CLASS_READY(ready),
    .PAUSE_IN(pause), .PAUSE_TICK(ptick), .SHAPE_TICK(stick),
    .TX_DONE(done), .SLOT_REQ(slot), .SEL_VALID(sel_v),
    .SEL_CLASS(sel_cls), .SEL_GROUP(sel_grp), .CLASS_PAUSED(paused),
    .LAST_SERVED_VALID(ls_v), .LAST_SERVED_GROUP_POINTER(ls_ptr)
  );

  etsch_queue_model u_etsch_queue_model (
    .clk(SYS_CLK), .rst_n(RESETN), .load(load), .load_cnt(cnt),
    .sel_valid(sel_v), .sel_class(sel_cls), .ready(ready), .done(done)
  );

  // ********
  // Bench tasks
  // ********
  task automatic tick_n(input int n);
    repeat (n) @(posedge SYS_CLK);
    #1;
  endtask

  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic give_verdict();
    $display("Checks made %0d, mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Every test restarts so deficits and tokens begin at zero
  task automatic restart();
    RESETN = 1'b0;
    tick_n(5);
    RESETN = 1'b1;
    load = 1'b1;
    tick_n(1);
    load = 1'b0;
    tick_n(1);
  endtask

  task automatic defaults();
    cnt = '0;
    for (int g = 0; g < 12; g++) begin
      cls_cfg[g] = {4'(g), 1'b0};
      grp_cfg[g] = {1'b0, 3'h0, 20'h000C8, 4'(g)};
      shp_cfg[g] = '0;
    end
  endtask

  // Waits long enough for the frame length to be charged back
  task automatic req(input logic v, input logic [3:0] c,
                     input logic [4:0] p);
    slot = 1'b1;
    tick_n(1);
    slot = 1'b0;
    chk("sel_valid", {15'h0000, v}, {15'h0000, sel_v});
    if (v) chk("sel_class", {12'h000, c}, {12'h000, sel_cls});
    if (v) chk("sel_group", {12'h000, cls_cfg[c].group},
               {12'h000, sel_grp});
    chk("pointer", {11'h000, p}, {11'h000, ls_v, ls_ptr});
    tick_n(1);
    chk("sel_valid low", 16'h0000, {15'h0000, sel_v});
    tick_n(3);
  endtask

  task automatic send_pause(input logic cb, input logic [11:0] m,
                            input logic [15:0] t);
    pause.valid = 1'b1;
    pause.class_based = cb;
    pause.mask = m;
    pause.std_time = t;
    for (int c = 0; c < 12; c++) pause.cls_time[c] = t;
    tick_n(1);
    pause.valid = 1'b0;
    tick_n(1);
  endtask

  initial begin
    defaults();
    restart();
    chk("reset outputs", 16'h0000,
        {2'h0, sel_v, ls_v, sel_cls, sel_grp, ls_ptr});
    $display("Test reset done");
    cnt[0] = 4'h8;
    cnt[1] = 4'h8;
    restart();
    for (int i = 0; i < 5; i++)
      req(1'b1, drr_seq[i], {1'b1, drr_seq[i]});
    $display("Test round robin done");
    defaults();
    grp_cfg[11].strict = 1'b1;
    grp_cfg[0].strict = 1'b1;
    cnt[0] = 4'h1;
    cnt[5] = 4'h1;
    cnt[11] = 4'h1;
    restart();
    req(1'b1, 4'hB, 5'h00);
    req(1'b1, 4'h5, 5'h15);
    req(1'b1, 4'h0, 5'h00);
    req(1'b0, 4'h0, 5'h00);
    $display("Test strict done");
    defaults();
    cls_cfg[2] = {4'h1, 1'b1};
    cls_cfg[3] = {4'h1, 1'b0};
    cnt[2] = 4'h2;
    cnt[3] = 4'h2;
    restart();
    req(1'b1, 4'h2, 5'h11);
    req(1'b1, 4'h2, 5'h11);
    req(1'b1, 4'h3, 5'h11);
    $display("Test class preference done");
    defaults();
    cnt[3] = 4'h8;
    cnt[7] = 4'h8;
    restart();
    send_pause(1'b1, 12'h080, 16'h0003);
    chk("paused", 16'h0080, {4'h0, paused});
    req(1'b1, 4'h3, 5'h13);
    send_pause(1'b0, 12'h000, 16'h0002);
    chk("paused", 16'h0FFF, {4'h0, paused});
    req(1'b0, 4'h0, 5'h13);
    send_pause(1'b0, 12'h000, 16'h0000);
    chk("paused", 16'h0000, {4'h0, paused});
    req(1'b1, 4'h3, 5'h13);
    send_pause(1'b1, 12'h080, 16'h0001);
    ptick = 1'b1;
    tick_n(1);
    ptick = 1'b0;
    tick_n(1);
    chk("paused", 16'h0000, {4'h0, paused});
    $display("Test pause done");
    // Classes 2 and 3 held back so the pointer sits below group 2
    defaults();
    grp_cfg[1].prio_set = 3'h1;
    grp_cfg[2].prio_set = 3'h1;
    cnt[1] = 4'h2;
    cnt[2] = 4'h1;
    cnt[3] = 4'h1;
    restart();
    send_pause(1'b1, 12'h00C, 16'h0009);
    req(1'b1, 4'h1, 5'h11);
    req(1'b1, 4'h1, 5'h11);
    send_pause(1'b0, 12'h000, 16'h0000);
    req(1'b1, 4'h2, 5'h12);
    req(1'b1, 4'h3, 5'h13);
    $display("Test priority sets done");
    defaults();
    shp_cfg[4] = {1'b1, 16'h0010, 16'h0001};
    cnt[4] = 4'h8;
    restart();
    req(1'b0, 4'h0, 5'h00);
    stick = 1'b1;
    tick_n(1);
    stick = 1'b0;
    tick_n(1);
    req(1'b1, 4'h4, 5'h14);
    req(1'b0, 4'h0, 5'h14);
    chk("ready", 16'h0010, {4'h0, ready});
    $display("Test shaping done");
    give_verdict();
  end

  initial begin
    #100000;
    err_count++;
    $display("Watchdog expired");
    give_verdict();
  end
endmodule
